// *** verilog/reg_map_hub.sv ***
/*
 * system register access hub: arbitrates the processor, the debug scan port
 * and the host bridge, decodes the block windows, strobes the selected block
 * and holds a local bank that shows every field access kind. assumes blocks
 * answer reads combinationally in the cycle their select is high.
 */
`timescale 1ns/1ps
`default_nettype none
module reg_map_hub (
    input  wire logic                                         core_clk,
    input  wire logic                                         rst_n,
    input  wire logic                                         proc_valid,
    output logic                                              proc_ready,
    input  wire reg_map_pkg::bus_req_s                        proc_req,
    output logic                                              proc_ack,
    output reg_map_pkg::bus_rsp_s                             proc_rsp,
    input  wire logic                                         dbg_valid,
    output logic                                              dbg_ready,
    input  wire reg_map_pkg::bus_req_s                        dbg_req,
    output logic                                              dbg_ack,
    output reg_map_pkg::bus_rsp_s                             dbg_rsp,
    input  wire logic                                         host_valid,
    output logic                                              host_ready,
    input  wire reg_map_pkg::host_req_s                       host_req,
    output logic                                              host_ack,
    output reg_map_pkg::bus_rsp_s                             host_rsp,
    output logic      [reg_map_pkg::NUM_BLOCKS-1:0]           blk_sel,
    output reg_map_pkg::blk_acc_s                             blk_acc,
    input  wire logic [reg_map_pkg::NUM_BLOCKS-1:0][31:0]     blk_rdata,
    input  wire logic [reg_map_pkg::LOCAL_REGS-1:0][15:0]     loc_hw_set,
    input  wire logic [reg_map_pkg::LOCAL_REGS-1:0][15:0]     loc_hw_clr,
    output logic      [reg_map_pkg::LOCAL_REGS-1:0][15:0]     loc_q
);
    import reg_map_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    // one-hot window hit for a byte address; windows never overlap
    function automatic logic [NUM_BLOCKS-1:0] win_hit(input logic [ADDR_W-1:0] a);
        logic [NUM_BLOCKS-1:0] h;
        h = '0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            h[i] = ((a & ~WIN_TABLE[i].mask) == WIN_TABLE[i].base);
        end
        return h;
    endfunction

    // base address of the block owning a logical device number, top bit = hit
    function automatic logic [ADDR_W:0] ldn_base(input logic [LDN_W-1:0] n);
        logic [ADDR_W:0] r;
        r = '0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            if (WIN_TABLE[i].has_ldn && WIN_TABLE[i].ldn == n) begin
                r = {1'b1, WIN_TABLE[i].base};
            end
        end
        return r;
    endfunction

    // ****************************************
    // arbitration: processor, then debug, then host
    // ****************************************
    logic grant_proc;                            // processor taken this cycle
    logic grant_dbg;                             // debug port taken
    logic grant_host;                            // host bridge taken
    logic taken;                                 // any request taken

    assign grant_proc = proc_valid;
    assign grant_dbg  = dbg_valid & ~proc_valid;
    assign grant_host = host_valid & ~proc_valid & ~dbg_valid;
    assign taken      = grant_proc | grant_dbg | grant_host;
    assign proc_ready = 1'b1;
    assign dbg_ready  = ~proc_valid;
    assign host_ready = ~proc_valid & ~dbg_valid;

    // ****************************************
    // host translation through the logical device bank
    // ****************************************
    logic [ADDR_W:0]   host_lk;                  // hit flag and block base
    logic [ADDR_W-1:0] host_addr;                // translated system address
    logic              host_miss;                // no block owns this number

    // the host names a device and an offset, never a raw address
    assign host_lk   = ldn_base(host_req.ldn);
    assign host_addr = host_lk[ADDR_W-1:0] | {22'h0, host_req.offset};
    assign host_miss = ~host_lk[ADDR_W];
    // two-wire hosts have no port here: firmware serves them

    // ****************************************
    // current access
    // ****************************************
    logic              cur_write;                // selected master writes
    logic [ADDR_W-1:0] cur_addr;                 // selected address
    logic [DATA_W-1:0] cur_wdata;                // selected write data
    logic              cur_bad;                  // refused before decode

    // debug port shares the processor decode path
    assign cur_write = grant_proc ? proc_req.write :
                       grant_dbg  ? dbg_req.write  : host_req.write;
    assign cur_addr  = grant_proc ? proc_req.addr  :
                       grant_dbg  ? dbg_req.addr   : host_addr;
    assign cur_wdata = grant_proc ? proc_req.wdata :
                       grant_dbg  ? dbg_req.wdata  : host_req.wdata;
    assign cur_bad   = grant_host & host_miss;

    // ****************************************
    // decode and block strobes
    // ****************************************
    logic [NUM_BLOCKS-1:0] hit;                  // window hits of cur_addr
    logic                  mapped;               // some window hit
    logic [ADDR_W-1:0]     win_mask;             // mask of the hit window

    assign hit     = win_hit(cur_addr);
    assign blk_sel = (taken && !cur_bad) ? hit : '0;
    assign mapped  = |blk_sel;

    // offset inside the hit window
    always_comb begin
        win_mask = '0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            if (hit[i]) begin
                win_mask = WIN_TABLE[i].mask;
            end
        end
    end

    assign blk_acc.write  = mapped & cur_write;
    assign blk_acc.read   = mapped & ~cur_write;
    assign blk_acc.offset = cur_addr[BOFF_W-1:0] & win_mask[BOFF_W-1:0];
    assign blk_acc.wdata  = cur_wdata;

    // ****************************************
    // local bank of access kinds
    // ****************************************
    logic                              loc_sel;  // local window selected
    logic [LREG_W-1:0]                 loc_idx;  // word index in local window
    logic [LOCAL_REGS-1:0]             loc_wr;   // per field write pulse
    logic [LOCAL_REGS-1:0]             loc_rd;   // per field read pulse
    logic [LOCAL_REGS-1:0][FIELD_W-1:0] loc_rdata; // per field read value
    logic [DATA_W-1:0]                 loc_word; // local read word

    assign loc_sel = blk_sel[LOCAL_IDX];
    assign loc_idx = cur_addr[LREG_LSB +: LREG_W];

    generate
        for (genvar g = 0; g < LOCAL_REGS; g++) begin : g_field
            // strobes only for the word that is addressed
            assign loc_wr[g] = loc_sel & cur_write  & (loc_idx == LREG_W'(g));
            assign loc_rd[g] = loc_sel & ~cur_write & (loc_idx == LREG_W'(g));
            access_field #(
                .KIND (LOCAL_KINDS[g])
            ) u_field (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .wr       (loc_wr[g]),
                .rd       (loc_rd[g]),
                .wdata    (cur_wdata[FIELD_W-1:0]),
                .hw_set   (loc_hw_set[g]),
                .hw_clr   (loc_hw_clr[g]),
                .q        (loc_q[g]),
                .rdata    (loc_rdata[g])
            );
        end
    endgenerate

    // unused words and the upper bits of each word read zero
    assign loc_word = (loc_idx < LREG_W'(LOCAL_REGS)) ?
                      {FIELD_PAD, loc_rdata[loc_idx[2:0]]} : DATA_ZERO;

    // ****************************************
    // read data selection
    // ****************************************
    logic [DATA_W-1:0] rd_word;                  // data of the hit block

    // one-hot select, so an or-reduction is a mux
    always_comb begin
        rd_word = DATA_ZERO;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            if (blk_sel[i] && i != LOCAL_IDX) begin
                rd_word = rd_word | blk_rdata[i];
            end
        end
        if (loc_sel) begin
            rd_word = loc_word;
        end
    end

    // ****************************************
    // response registers
    // ****************************************
    bus_rsp_s  rsp_reg;                          // answer of the last access
    bus_rsp_s  rsp_next;                         // answer being formed
    logic [2:0] ack_reg;                         // proc, dbg, host ack
    logic [2:0] ack_next;                        // next ack pulses

    // unmapped or refused accesses answer error with zero data
    assign rsp_next.err   = taken & ~mapped;
    assign rsp_next.rdata = (taken && mapped && !cur_write) ? rd_word : DATA_ZERO;
    assign ack_next       = {grant_host, grant_dbg, grant_proc};

    // answer one cycle after the request is taken
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_reg <= '0;
            ack_reg <= 3'h0;
        end else begin
            rsp_reg <= taken ? rsp_next : rsp_reg;
            ack_reg <= ack_next;
        end
    end

    assign proc_ack = ack_reg[0];
    assign dbg_ack  = ack_reg[1];
    assign host_ack = ack_reg[2];
    assign proc_rsp = rsp_reg;
    assign dbg_rsp  = rsp_reg;
    assign host_rsp = rsp_reg;
endmodule
`default_nettype wire

// *** verilog/reg_map_pkg.sv ***
/*
 * constants, types and the block window table shared by the register map hub
 * and its field cell; assumes one system clock and one synchronous reset.
 */
// Function
// - reserved locations read zero, ignore writes
// - read-only fields ignore bus writes
// - write-only fields read back all zeros
// - set-on-read field sets when read
// - clear-on-read returns value, then clears
// - written ones clear stored bits
// - written zeros clear stored bits
// - written ones set stored bits
// - written zeros set stored bits
// - processor reaches blocks at base plus offset
// - debug port uses the same decode
// - host reaches blocks only via device bank
// - no hardware path for two-wire hosts
// - host-visible blocks carry logical device numbers
`default_nettype none
package reg_map_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W     = 32;          // system address width
    localparam int DATA_W     = 32;          // bus data width
    localparam int LDN_W      = 6;           // logical device number width
    localparam int HOFF_W     = 10;          // host offset width inside a block
    localparam int BOFF_W     = 12;          // offset width given to blocks
    localparam int FIELD_W    = 16;          // implemented bits of a local field
    localparam int NUM_BLOCKS = 14;          // decoded windows
    localparam int LOCAL_REGS = 8;           // local demonstration registers
    localparam int LOCAL_IDX  = 13;          // table slot of the local bank
    localparam int LREG_LSB   = 2;           // word index position in offset
    localparam int LREG_W     = 6;           // word index width in local window

    // ****************************************
    // reset values and fills
    // ****************************************
    localparam logic [DATA_W-1:0]         DATA_ZERO  = 32'h0000_0000;
    localparam logic [FIELD_W-1:0]        FIELD_RST  = 16'h0000;
    localparam logic [FIELD_W-1:0]        FIELD_ONES = 16'hffff;
    localparam logic [DATA_W-FIELD_W-1:0] FIELD_PAD  = 16'h0000;

    // ****************************************
    // field access kinds
    // ****************************************
    typedef enum {
        FK_READ_ONLY, FK_WRITE_ONLY, FK_SET_ON_READ, FK_CLEAR_ON_READ,
        FK_W1_CLEAR, FK_W0_CLEAR, FK_W1_SET, FK_W0_SET
    } field_kind_e;

    // local bank: one field per word, in this order from offset 0h
    localparam field_kind_e LOCAL_KINDS [LOCAL_REGS] = '{
        FK_READ_ONLY, FK_WRITE_ONLY, FK_SET_ON_READ, FK_CLEAR_ON_READ,
        FK_W1_CLEAR, FK_W0_CLEAR, FK_W1_SET, FK_W0_SET};

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic              write;            // 1 write, 0 read
        logic [ADDR_W-1:0] addr;             // byte address
        logic [DATA_W-1:0] wdata;            // write data
    } bus_req_s;

    typedef struct packed {
        logic              err;              // unmapped or refused
        logic [DATA_W-1:0] rdata;            // read data
    } bus_rsp_s;

    typedef struct packed {
        logic              write;            // 1 write, 0 read
        logic [LDN_W-1:0]  ldn;              // logical device number
        logic [HOFF_W-1:0] offset;           // byte offset in the block
        logic [DATA_W-1:0] wdata;            // write data
    } host_req_s;

    typedef struct packed {
        logic              write;            // write strobe
        logic              read;             // read strobe
        logic [BOFF_W-1:0] offset;           // byte offset in the window
        logic [DATA_W-1:0] wdata;            // write data
    } blk_acc_s;

    typedef struct packed {
        logic [ADDR_W-1:0] base;             // window base
        logic [ADDR_W-1:0] mask;             // window size minus one
        logic              has_ldn;          // host visible
        logic [LDN_W-1:0]  ldn;              // logical device number
    } win_s;

    // ****************************************
    // block windows
    // ****************************************
    localparam win_s WIN_TABLE [NUM_BLOCKS] = '{
        '{32'h4000_0400, 32'h0000_03ff, 1'b0, 6'h00},   // watchdog
        '{32'h4000_0c00, 32'h0000_001f, 1'b0, 6'h00},   // basic timer 16 0
        '{32'h4000_0c20, 32'h0000_001f, 1'b0, 6'h00},   // basic timer 16 1
        '{32'h4000_5800, 32'h0000_000f, 1'b0, 6'h00},   // pwm 0
        '{32'h4000_6000, 32'h0000_000f, 1'b0, 6'h00},   // tach 0
        '{32'h4008_0000, 32'h0000_00ff, 1'b0, 6'h00},   // debug port block
        '{32'h4008_0100, 32'h0000_00ff, 1'b0, 6'h00},   // power, clocks, resets
        '{32'h4008_1000, 32'h0000_03ff, 1'b0, 6'h00},   // gpio
        '{32'h400f_0000, 32'h0000_03ff, 1'b1, 6'h00},   // mailbox
        '{32'h400f_0400, 32'h0000_03ff, 1'b1, 6'h01},   // keyboard controller
        '{32'h400f_0800, 32'h0000_03ff, 1'b1, 6'h02},   // acpi ec 0
        '{32'h400f_2400, 32'h0000_03ff, 1'b1, 6'h09},   // uart 0
        '{32'h400f_2800, 32'h0000_03ff, 1'b1, 6'h0a},   // uart 1
        '{32'h400f_ff00, 32'h0000_00ff, 1'b1, 6'h3f}};  // global config (local)
endpackage
`default_nettype wire

// *** verilog/access_field.sv ***
/*
 * one stored register field with a fixed access kind; assumes one-cycle
 * read and write strobes from the hub and hardware set/clear from the block.
 */
`timescale 1ns/1ps
`default_nettype none
module access_field
    import reg_map_pkg::*;
#(
    parameter field_kind_e KIND = FK_READ_ONLY
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   wr,       // bus write pulse
    input  wire logic                   rd,       // bus read pulse
    input  wire logic [FIELD_W-1:0]     wdata,    // bus write data
    input  wire logic [FIELD_W-1:0]     hw_set,   // status value or set events
    input  wire logic [FIELD_W-1:0]     hw_clr,   // hardware clear events
    output logic      [FIELD_W-1:0]     q,        // stored value
    output logic      [FIELD_W-1:0]     rdata     // value seen by the bus
);
    // ****************************************
    // software set and clear terms
    // ****************************************
    logic [FIELD_W-1:0] q_reg;                    // stored bits
    logic [FIELD_W-1:0] q_next;                   // next stored bits
    logic [FIELD_W-1:0] sw_set;                   // bus driven set
    logic [FIELD_W-1:0] sw_clr;                   // bus driven clear

    assign sw_set = (KIND == FK_SET_ON_READ && rd)  ? FIELD_ONES :
                    (KIND == FK_W1_SET && wr)       ? wdata :
                    (KIND == FK_W0_SET && wr)       ? ~wdata :
                    FIELD_RST;
    assign sw_clr = (KIND == FK_CLEAR_ON_READ && rd) ? FIELD_ONES :
                    (KIND == FK_W1_CLEAR && wr)      ? wdata :
                    (KIND == FK_W0_CLEAR && wr)      ? ~wdata :
                    FIELD_RST;

    // ****************************************
    // next value: any set wins over any clear
    // ****************************************
    assign q_next = (KIND == FK_READ_ONLY)  ? hw_set :
                    (KIND == FK_WRITE_ONLY) ? (wr ? wdata : q_reg) :
                    ((q_reg & ~(sw_clr | hw_clr)) | sw_set | hw_set);

    // stored bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q_reg <= FIELD_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // write-only reads back zero; others show the value before this edge
    assign rdata = (KIND == FK_WRITE_ONLY) ? FIELD_RST : q_reg;
    assign q     = q_reg;
endmodule
`default_nettype wire

// *** verification/reg_map_sva.sv ***
/*
 * port checker for the register map hub.
 * assumes the local bank at 400f_ff00 and hw clear inputs held at zero.
 */
`timescale 1ns/1ps
`default_nettype none
module reg_map_sva
    import reg_map_pkg::*;
(
    input wire logic                             core_clk,
    input wire logic                             rst_n,
    input wire logic                             proc_valid,
    input wire logic                             proc_ack,
    input wire bus_req_s                         proc_req,
    input wire bus_rsp_s                         proc_rsp,
    input wire logic                             dbg_valid,
    input wire logic                             dbg_ack,
    input wire logic                             host_valid,
    input wire logic                             host_ready,
    input wire logic                             host_ack,
    input wire host_req_s                        host_req,
    input wire logic [NUM_BLOCKS-1:0]            blk_sel,
    input wire blk_acc_s                         blk_acc,
    input wire logic [LOCAL_REGS-1:0][15:0]      loc_hw_set,
    input wire logic [LOCAL_REGS-1:0][15:0]      loc_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // processor read at any address, and its address
    wire logic           prd = proc_valid && !proc_req.write;
    wire logic [31:0]    pa  = proc_req.addr;

    a_take_ack: assert property (proc_valid |=> proc_ack && !dbg_ack && !host_ack)
        else $error("processor take not answered next cycle");
    a_dbg_answer: assert property (dbg_valid && !proc_valid |=> dbg_ack && !proc_ack)
        else $error("debug take not answered next cycle");
    a_wdt_decode: assert property (proc_valid && pa[31:10] == 22'h10_0001
        |-> blk_sel == 14'h0001)
        else $error("watchdog window not selected");
    a_host_ldn: assert property (host_valid && host_ready && host_req.ldn == 6'h0a
        |-> blk_sel[12] && blk_acc.offset[9:0] == host_req.offset)
        else $error("host ldn a not routed to its block");
    a_sel_onehot: assert property ($onehot0(blk_sel)
        && (proc_valid || dbg_valid || host_valid || blk_sel == '0))
        else $error("block select not one-hot");
    a_unmapped_err: assert property (proc_valid && blk_sel == '0
        |=> proc_rsp.err && proc_rsp.rdata == DATA_ZERO)
        else $error("unmapped access without error");
    a_blk_write: assert property (proc_valid && proc_req.write && blk_sel != '0
        |-> blk_acc.write && !blk_acc.read && blk_acc.wdata == proc_req.wdata)
        else $error("block write strobe not raised");
    a_wo_zero: assert property (prd && pa == 32'h400f_ff04 |=> proc_rsp.rdata == DATA_ZERO)
        else $error("write-only field read nonzero");
    a_sor_set: assert property (prd && pa == 32'h400f_ff08 |=> loc_q[2] == FIELD_ONES)
        else $error("set-on-read field not set");
    a_cor_clear: assert property (prd && pa == 32'h400f_ff0c && loc_hw_set[3] == 16'h0000
        |=> loc_q[3] == 16'h0000 && proc_rsp.rdata[15:0] == $past(loc_q[3]))
        else $error("clear-on-read field wrong");
    a_w1c_clear: assert property (proc_valid && proc_req.write && pa == 32'h400f_ff10
        && loc_hw_set[4] == 16'h0000
        |=> loc_q[4] == ($past(loc_q[4]) & ~$past(proc_req.wdata[15:0])))
        else $error("write-one-clear field wrong");
    a_resv_zero: assert property (prd && pa[31:8] == 24'h400fff && pa[7:0] >= 8'h20
        |=> proc_rsp.rdata == DATA_ZERO)
        else $error("reserved location read nonzero");

    c_both: cover property (proc_valid && host_valid);
    c_host: cover property (host_ack);
    c_err: cover property (proc_ack && proc_rsp.err);
endmodule
bind reg_map_hub reg_map_sva chk_u (.core_clk(core_clk), .rst_n(rst_n), .proc_valid(proc_valid),
    .proc_ack(proc_ack), .proc_req(proc_req), .proc_rsp(proc_rsp), .dbg_valid(dbg_valid),
    .dbg_ack(dbg_ack), .host_valid(host_valid), .host_ready(host_ready), .host_ack(host_ack),
    .host_req(host_req), .blk_sel(blk_sel), .blk_acc(blk_acc), .loc_hw_set(loc_hw_set),
    .loc_q(loc_q));
`default_nettype wire

// *** verification/blk_model.sv ***
/*
 * far-side block register banks: a selected block answers with its index
 * and offset; assumes the hub samples read data in the select cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module blk_model
    import reg_map_pkg::*;
(
    input wire logic [NUM_BLOCKS-1:0]            blk_sel,
    input wire blk_acc_s                         blk_acc,
    output logic [NUM_BLOCKS-1:0][31:0]          blk_rdata
);
    // unselected blocks show the inverse, so stale data never matches
    always_comb begin
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            blk_rdata[i] = {8'hb0, 8'(i), 4'h0, blk_acc.offset} ^ {32{!blk_sel[i]}};
        end
    end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/*
 * self-checking bench for the register map hub and its local bank.
 * assumes one 10 MHz clock; hardware clear inputs are held at zero by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import reg_map_pkg::*;
    localparam logic [31:0] L = 32'h400f_ff00;  // local bank base
    logic core_clk, rst_n, proc_valid, dbg_valid, host_valid;
    logic proc_ready, dbg_ready, host_ready, proc_ack, dbg_ack, host_ack;
    bus_req_s proc_req, dbg_req;
    host_req_s host_req;
    bus_rsp_s proc_rsp, dbg_rsp, host_rsp;
    logic [NUM_BLOCKS-1:0] blk_sel;
    blk_acc_s blk_acc;
    logic [NUM_BLOCKS-1:0][31:0] blk_rdata;
    logic [LOCAL_REGS-1:0][15:0] loc_hw_set, loc_q;
    int failures = 0, comparisons = 0;

    reg_map_hub dut_u (.core_clk(core_clk), .rst_n(rst_n), .proc_valid(proc_valid),
        .proc_ready(proc_ready), .proc_req(proc_req), .proc_ack(proc_ack), .proc_rsp(proc_rsp),
        .dbg_valid(dbg_valid), .dbg_ready(dbg_ready), .dbg_req(dbg_req), .dbg_ack(dbg_ack),
        .dbg_rsp(dbg_rsp), .host_valid(host_valid), .host_ready(host_ready),
        .host_req(host_req), .host_ack(host_ack), .host_rsp(host_rsp), .blk_sel(blk_sel),
        .blk_acc(blk_acc), .blk_rdata(blk_rdata), .loc_hw_set(loc_hw_set),
        .loc_hw_clr('0), .loc_q(loc_q));
    blk_model far_u (.blk_sel(blk_sel), .blk_acc(blk_acc), .blk_rdata(blk_rdata));

    // one compare, counted
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one access by master m (0 proc, 1 dbg, 2 host); exp is {err, rdata}
    task automatic acc(input int m, input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       input logic [32:0] exp);
        bus_rsp_s r;
        logic k;
        @(negedge core_clk);
        if (m == 0) begin
            proc_valid = 1'b1;
            proc_req = '{wr, a, wd};
        end else if (m == 1) begin
            dbg_valid = 1'b1;
            dbg_req = '{wr, a, wd};
        end else begin
            host_valid = 1'b1;
            host_req = '{wr, a[15:10], a[9:0], wd};
        end
        @(negedge core_clk);
        k = (m == 0) ? proc_ack : (m == 1) ? dbg_ack : host_ack;
        r = (m == 0) ? proc_rsp : (m == 1) ? dbg_rsp : host_rsp;
        {proc_valid, dbg_valid, host_valid} = 3'b000;
        chk("ack", 32'h1, {31'h0, k});
        chk("err", {31'h0, exp[32]}, {31'h0, r.err});
        if (!wr) chk("rdata", exp[31:0], r.rdata);
    endtask

    // one-cycle hardware set pulse on a local field
    task automatic pulse(input int i, input logic [15:0] v);
        @(negedge core_clk);
        loc_hw_set[i] = v;
        @(negedge core_clk);
        loc_hw_set[i] = 16'h0000;
    endtask

    task automatic t_map;
        for (int i = 0; i < NUM_BLOCKS - 1; i++) begin
            acc(0, 0, WIN_TABLE[i].base + 32'h4, 0, {9'h0b0, 8'(i), 16'h0004});
            acc(1, 0, WIN_TABLE[i].base + 32'h8, 0, {9'h0b0, 8'(i), 16'h0008});
        end
        acc(1, 0, 32'h5000_0000, 0, {1'b1, 32'h0});
        acc(0, 1, 32'h4000_0800, 32'hffff_ffff, {1'b1, 32'h0});
        $display("test map done");
    endtask

    task automatic t_kinds;
        acc(0, 1, L, 32'h0000_ffff, '0);
        acc(0, 0, L, 0, {17'h0, 16'h5a5a});
        acc(0, 1, L + 32'h04, 32'h0000_1234, '0);
        chk("wo field", 32'h1234, {16'h0, loc_q[1]});
        acc(0, 0, L + 32'h04, 0, '0);
        acc(0, 0, L + 32'h08, 0, '0);
        acc(0, 0, L + 32'h08, 0, {17'h0, 16'hffff});
        pulse(3, 16'h00c3);
        acc(0, 1, L + 32'h0c, 32'h0000_0000, '0);
        acc(0, 0, L + 32'h0c, 0, {17'h0, 16'h00c3});
        acc(0, 0, L + 32'h0c, 0, '0);
        pulse(4, 16'hffff);
        pulse(5, 16'hffff);
        acc(0, 1, L + 32'h10, 32'hffff_00ff, '0);
        chk("w1c field", 32'hff00, {16'h0, loc_q[4]});
        acc(0, 1, L + 32'h14, 32'hffff_00ff, '0);
        chk("w0c field", 32'h00ff, {16'h0, loc_q[5]});
        acc(0, 1, L + 32'h18, 32'h0000_00f0, '0);
        acc(0, 0, L + 32'h18, 0, {17'h0, 16'h00f0});
        acc(0, 1, L + 32'h1c, 32'hffff_fff0, '0);
        chk("w0s field", 32'h000f, {16'h0, loc_q[7]});
        acc(0, 1, L + 32'h20, 32'hffff_ffff, '0);
        acc(0, 0, L + 32'h20, 0, '0);
        acc(1, 0, L + 32'hfc, 0, '0);
        $display("test field kinds done");
    endtask

    task automatic t_host;
        logic [5:0] ldns [5] = '{6'h00, 6'h01, 6'h02, 6'h09, 6'h0a};
        for (int i = 0; i < 5; i++) begin
            acc(2, 0, {16'h0, ldns[i], 10'h00c}, 0, {9'h0b0, 8'(i + 8), 16'h000c});
        end
        acc(2, 1, {16'h0, 6'h3f, 10'h010}, 32'h0000_0f00, '0);
        chk("host w1c", 32'hf000, {16'h0, loc_q[4]});
        acc(2, 0, {16'h0, 6'h03, 10'h000}, 0, {1'b1, 32'h0});
        $display("test host done");
    endtask

    task automatic t_prio;
        @(negedge core_clk);
        proc_valid = 1'b1;
        proc_req = '{1'b0, L + 32'h18, 32'h0};
        host_valid = 1'b1;
        host_req = '{1'b0, 6'h3f, 10'h018, 32'h0};
        #1 chk("host ready", 32'h0, {31'h0, host_ready});
        @(negedge core_clk);
        proc_valid = 1'b0;
        chk("proc ack", 32'h1, {31'h0, proc_ack});
        chk("host early", 32'h0, {31'h0, host_ack});
        @(negedge core_clk);
        host_valid = 1'b0;
        chk("host ack", 32'h1, {31'h0, host_ack});
        chk("host rdata", 32'h00f0, host_rsp.rdata);
        $display("test priority done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // clock, reset and test sequence
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, proc_valid, dbg_valid, host_valid} = 4'h0;
        {proc_req, dbg_req, host_req} = '0;
        loc_hw_set = '0;
        loc_hw_set[0] = 16'h5a5a;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_map();
        t_kinds();
        t_host();
        t_prio();
        print_verdict();
    end
    // watchdog at 20000 cycles: the tests need well under that
    initial begin
        #2_000_000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
